/* File: slvm_top.sv */
/*
  supply low voltage monitor: apb registers, detector and bandgap enables,
  synchronised low flag and qualified interrupt request with idle wake.
  assumes an external comparator that is high while the supply is below
  the trip level it is given, and a core that reports its sleep state.
*/
`timescale 1ns/10ps

// Contract
// - low flag bit 5 follows the comparator
// - detector_enable bit 4 powers the detector
// - bits 7:6 read zero, flag read-only
// - bandgap on for buffer, detector or reset
// - detector forced off while asleep
// - flag may toggle near the threshold
// - request set after irq delay elapses
// - set request raises interrupt to core
// - request wakes device from idle
// - request gated by its enable bit
// - request held in irq_control_1 bit 5
// - enable held in irq_control_1 bit 1
// - global enable off blocks the interrupt
module slvm_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog and power
  input wire logic comp_low,
  input wire logic sleep_state,
  input wire logic idle_state,
  input wire logic low_voltage_reset_en,
  output logic detector_on,
  output logic bandgap_on,
  output logic [2:0] threshold_level,
  // interrupt
  output logic supply_irq,
  output logic idle_wake
);
  import slvm_pkg::*;

  typedef struct packed {
    logic [2:0] thr;
    logic bgen;
    logic deten;
    logic flag;
    logic irq_req;
    logic irq_en;
    logic gie;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic det_on;
    logic bg_on;
    logic irq;
    logic wake;
  } slvm_top_type;
  slvm_top_type st_q, st_d;

  logic comp_sync;
  logic delay_done;
  logic access;
  logic wr;

  slvm_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comp_low),
    .sync_out(comp_sync)
  );

  slvm_delay u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .flag(st_q.flag),
    .expired(delay_done)
  );

  assign access = psel && penable && !st_q.ready;
  assign wr = access && pwrite;

  always_comb begin
    st_d = st_q;
    st_d.ready = access;
    st_d.err = 1'b0;
    st_d.det_on = st_q.deten && !sleep_state;
    st_d.bg_on = st_q.bgen || (st_q.deten && !sleep_state) || low_voltage_reset_en;
    st_d.flag = st_q.det_on && comp_sync;
    // register writes
    if (wr) begin
      case (paddr)
        SLVM_CTRL_OFFS: begin
          st_d.thr = pwdata[SLVM_THR_LSB +: 3];
          st_d.bgen = pwdata[SLVM_BGEN_BIT];
          st_d.deten = pwdata[SLVM_DETEN_BIT];
        end
        SLVM_IRQC_OFFS: begin
          st_d.irq_req = pwdata[SLVM_IRQREQ_BIT];
          st_d.irq_en = pwdata[SLVM_IRQEN_BIT];
        end
        SLVM_GIE_OFFS: st_d.gie = pwdata[0];
        SLVM_TRIP_OFFS: st_d.err = 1'b1;
        default: st_d.err = 1'b1;
      endcase
    end else if (access) begin
      case (paddr)
        SLVM_CTRL_OFFS, SLVM_IRQC_OFFS, SLVM_GIE_OFFS, SLVM_TRIP_OFFS: st_d.err = 1'b0;
        default: st_d.err = 1'b1;
      endcase
    end
    // hardware set wins over a software clear
    if (delay_done) begin
      st_d.irq_req = 1'b1;
    end
    // read data
    st_d.rdata = '0;
    if (access && !pwrite) begin
      case (paddr)
        SLVM_CTRL_OFFS: st_d.rdata = {26'h0, st_q.flag, st_q.deten, st_q.bgen, st_q.thr};
        SLVM_IRQC_OFFS: st_d.rdata = {26'h0, st_q.irq_req, 3'h0, st_q.irq_en, 1'b0};
        SLVM_GIE_OFFS: st_d.rdata = {31'h0, st_q.gie};
        SLVM_TRIP_OFFS: st_d.rdata = {16'h0, slvm_trip_mv(st_q.thr)};
        default: st_d.rdata = '0;
      endcase
    end
    st_d.irq = st_q.irq_req && st_q.irq_en && st_q.gie;
    // wake only on a new request while idle
    st_d.wake = idle_state && (st_q.wake || (st_d.irq_req && !st_q.irq_req));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign detector_on = st_q.det_on;
  assign bandgap_on = st_q.bg_on;
  assign threshold_level = st_q.thr;
  assign supply_irq = st_q.irq;
  assign idle_wake = st_q.wake;

  property p_sleep_off;
    @(posedge pclk) disable iff (!presetn)
      sleep_state |=> !detector_on;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("detector on in sleep");

  property p_det_on;
    @(posedge pclk) disable iff (!presetn)
      (st_q.deten && !sleep_state) |=> detector_on;
  endproperty
  a_det_on: assert property (p_det_on) else $error("detector not on");

  property p_bandgap;
    @(posedge pclk) disable iff (!presetn)
      (st_q.bgen || low_voltage_reset_en) |=> bandgap_on;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap off");

  property p_flag;
    @(posedge pclk) disable iff (!presetn)
      st_q.flag |-> $past(detector_on) && $past(comp_sync);
  endproperty
  a_flag: assert property (p_flag) else $error("flag without cause");

  property p_delay;
    @(posedge pclk) disable iff (!presetn)
      $rose(st_q.irq_req) && !$past(wr) |-> $past(delay_done);
  endproperty
  a_delay: assert property (p_delay) else $error("request set early");

  property p_gie;
    @(posedge pclk) disable iff (!presetn)
      !st_q.gie |=> !supply_irq;
  endproperty
  a_gie: assert property (p_gie) else $error("irq with global off");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (st_q.irq_req && st_q.irq_en && st_q.gie) |=> supply_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      (delay_done && !st_q.irq_req && idle_state) |=> idle_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no idle wake");

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
      (pready && paddr != SLVM_TRIP_OFFS) |-> prdata[31:6] == 26'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

  property p_thr_level;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == SLVM_CTRL_OFFS) |=>
        threshold_level == $past(pwdata[SLVM_THR_LSB +: 3]);
  endproperty
  a_thr_level: assert property (p_thr_level) else $error("threshold not applied");

  property p_flag_low;
    @(posedge pclk) disable iff (!presetn)
      !detector_on |=> !st_q.flag;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag with detector off");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      (detector_on && comp_sync) |=> st_q.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag missed low supply");

  property p_det_off;
    @(posedge pclk) disable iff (!presetn)
      !st_q.deten |=> !detector_on;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector not off");

  property p_bg_det;
    @(posedge pclk) disable iff (!presetn)
      (st_q.deten && !sleep_state) |=> bandgap_on;
  endproperty
  a_bg_det: assert property (p_bg_det) else $error("bandgap off with detector");

  property p_req_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q.irq_req && !wr) |=> st_q.irq_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request lost");

  property p_req_set;
    @(posedge pclk) disable iff (!presetn)
      delay_done |=> st_q.irq_req;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request not set");

  property p_en_hold;
    @(posedge pclk) disable iff (!presetn)
      !wr |=> $stable(st_q.irq_en);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable changed alone");

  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
      !st_q.irq_en |=> !supply_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enable off");

  property p_wake_idle;
    @(posedge pclk) disable iff (!presetn)
      !idle_state |=> !idle_wake;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("wake outside idle");

  property p_wake_preset;
    @(posedge pclk) disable iff (!presetn)
      (st_q.irq_req && !idle_wake) |=> !idle_wake;
  endproperty
  a_wake_preset: assert property (p_wake_preset) else $error("wake on old request");

  property p_sync;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn, 2) |-> comp_sync == $past(comp_low, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser lag wrong");
endmodule // slvm_top

/* File: slvm_pkg.sv */
/*
  package of the supply monitor: register offsets, field positions,
  reset values and timing counts.
  assumes a 100 MHz pclk and an apb slave with 32-bit data.
*/
package slvm_pkg;
  // register byte offsets
  localparam logic [7:0] SLVM_CTRL_OFFS = 8'h00;
  localparam logic [7:0] SLVM_IRQC_OFFS = 8'h04;
  localparam logic [7:0] SLVM_GIE_OFFS = 8'h08;
  localparam logic [7:0] SLVM_TRIP_OFFS = 8'h0C;
  // control register fields
  localparam int SLVM_THR_LSB = 0;
  localparam int SLVM_BGEN_BIT = 3;
  localparam int SLVM_DETEN_BIT = 4;
  localparam int SLVM_FLAG_BIT = 5;
  localparam logic [7:0] SLVM_CTRL_RST = 8'h00;
  // irq_control_1 fields
  localparam int SLVM_IRQEN_BIT = 1;
  localparam int SLVM_IRQREQ_BIT = 5;
  localparam logic [7:0] SLVM_IRQC_RST = 8'h00;
  // trip levels in millivolts, one per threshold code
  localparam logic [15:0] SLVM_MV_0 = 16'd2000;
  localparam logic [15:0] SLVM_MV_1 = 16'd2200;
  localparam logic [15:0] SLVM_MV_2 = 16'd2400;
  localparam logic [15:0] SLVM_MV_3 = 16'd2700;
  localparam logic [15:0] SLVM_MV_4 = 16'd3000;
  localparam logic [15:0] SLVM_MV_5 = 16'd3300;
  localparam logic [15:0] SLVM_MV_6 = 16'd3600;
  localparam logic [15:0] SLVM_MV_7 = 16'd4000;
  // timing
  localparam int SLVM_CLK_MHZ = 100;
  localparam int SLVM_IRQ_DELAY_US = 15;
  localparam int SLVM_IRQ_DELAY_CYC = SLVM_IRQ_DELAY_US * SLVM_CLK_MHZ;
  localparam int SLVM_CNT_W = 12;

  // trip level in millivolts for a threshold code
  function automatic logic [15:0] slvm_trip_mv(input logic [2:0] code);
    case (code)
      3'h0: slvm_trip_mv = SLVM_MV_0;
      3'h1: slvm_trip_mv = SLVM_MV_1;
      3'h2: slvm_trip_mv = SLVM_MV_2;
      3'h3: slvm_trip_mv = SLVM_MV_3;
      3'h4: slvm_trip_mv = SLVM_MV_4;
      3'h5: slvm_trip_mv = SLVM_MV_5;
      3'h6: slvm_trip_mv = SLVM_MV_6;
      default: slvm_trip_mv = SLVM_MV_7;
    endcase
  endfunction
endpackage

/* File: slvm_sync.sv */
/*
  two-flop synchroniser for the comparator output.
  assumes an asynchronous input and an active-low async reset.
*/
`timescale 1ns/10ps
module slvm_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } slvm_sync_type;
  slvm_sync_type st_q, st_d;

  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;
endmodule // slvm_sync

/* File: slvm_delay.sv */
/*
  irq delay timer: qualifies the low flag for a fixed count.
  assumes the flag is already synchronous to pclk.
*/
`timescale 1ns/10ps
module slvm_delay (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic flag,
  output logic expired
);
  import slvm_pkg::*;
  typedef struct packed {
    logic [SLVM_CNT_W-1:0] cnt;
    logic done;
  } slvm_delay_type;
  slvm_delay_type st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (!flag) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == SLVM_CNT_W'(SLVM_IRQ_DELAY_CYC - 1)) begin
      st_d.done = 1'b1;
      st_d.cnt = SLVM_CNT_W'(SLVM_IRQ_DELAY_CYC);
    end else if (st_q.cnt < SLVM_CNT_W'(SLVM_IRQ_DELAY_CYC - 1)) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired = st_q.done;
endmodule // slvm_delay

/* File: tb_top.sv */
/*
  self-checking bench of the supply monitor over apb with all eight thresholds, then two random ones.
  assumes slvm_pkg and slvm_top; one 100 MHz clock, async active-low reset.
*/
`timescale 1ns/10ps
module tb_top;
  import slvm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic comp_low, sleep_state, idle_state, low_voltage_reset_en;
  logic detector_on, bandgap_on, supply_irq, idle_wake;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [2:0] threshold_level;
  logic [2:0] c;
  logic b;
  int bad_count, checks, cyc, t0, n;
  int mv_tab[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

  slvm_top slvm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_low(comp_low), .sleep_state(sleep_state),
    .idle_state(idle_state), .low_voltage_reset_en(low_voltage_reset_en),
    .detector_on(detector_on),
    .bandgap_on(bandgap_on), .threshold_level(threshold_level),
    .supply_irq(supply_irq), .idle_wake(idle_wake));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // expected control read-back from its fields
  function automatic logic [31:0] ctrl_exp(input logic flg, input logic det, input logic bg,
    input logic [2:0] code);
    return {26'h0, flg, det, bg, code};
  endfunction

  // one apb transfer; result left in rv and ev
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t apb transfer timed out", $time);
      stop_test();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, comp_low, sleep_state, idle_state} = '0;
    low_voltage_reset_en = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(75));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, a[7:0], '0);
      chk(rv, '0);
    end
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      c = (i < 8) ? i[2:0] : 3'($urandom % 8);
      b = 1'($urandom % 2);
      apb(1'b1, SLVM_CTRL_OFFS, {24'h0, 8'hF0 | {4'h0, b, c}});
      apb(1'b0, SLVM_CTRL_OFFS, '0);
      chk(rv, ctrl_exp(1'b0, 1'b1, b, c));
      chk(threshold_level, c);
      chk({detector_on, bandgap_on}, 2'b11);
      apb(1'b0, SLVM_TRIP_OFFS, '0);
      chk(rv, mv_tab[c]);
      apb(1'b1, SLVM_CTRL_OFFS, {28'h0, b, c});
      repeat (2) @(posedge pclk);
      chk({detector_on, bandgap_on}, {1'b0, b});
    end
    low_voltage_reset_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(bandgap_on, 1'b1);
    apb(1'b1, SLVM_TRIP_OFFS, 32'h0000_00FF);
    chk(ev, 1'b1);
    apb(1'b0, 8'h10, '0);
    chk({ev, rv}, {1'b1, 32'h0});
    $display("register map done");
    apb(1'b1, SLVM_CTRL_OFFS, 32'h0000_0010);
    sleep_state <= 1'b1;
    comp_low <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(detector_on, 1'b0);
    apb(1'b0, SLVM_CTRL_OFFS, '0);
    chk(rv[5], 1'b0);
    sleep_state <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, SLVM_CTRL_OFFS, '0);
    chk(rv[5], 1'b1);
    comp_low <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, SLVM_CTRL_OFFS, '0);
    chk(rv[5], 1'b0);
    $display("sleep and flag done");
    repeat (6) begin
      comp_low <= 1'b1;
      repeat ($urandom % 300 + 1) @(posedge pclk);
      comp_low <= 1'b0;
      repeat ($urandom % 20 + 4) @(posedge pclk);
    end
    apb(1'b0, SLVM_IRQC_OFFS, '0);
    chk(rv, '0);
    $display("toggle done");
    apb(1'b1, SLVM_GIE_OFFS, 32'h1);
    apb(1'b1, SLVM_IRQC_OFFS, 32'h2);
    comp_low <= 1'b1;
    idle_state <= 1'b1;
    t0 = cyc;
    repeat (1400) @(posedge pclk);
    apb(1'b0, SLVM_IRQC_OFFS, '0);
    chk({rv, idle_wake}, {32'h2, 1'b0});
    n = 0;
    while (rv[5] !== 1'b1 && n < 60) begin
      apb(1'b0, SLVM_IRQC_OFFS, '0);
      n++;
    end
    chk((cyc - t0) >= SLVM_IRQ_DELAY_CYC && (cyc - t0) <= SLVM_IRQ_DELAY_CYC + 15, 1'b1);
    chk(supply_irq, 1'b1);
    chk(idle_wake, 1'b1);
    idle_state <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(idle_wake, 1'b0);
    apb(1'b1, SLVM_GIE_OFFS, '0);
    chk(supply_irq, 1'b0);
    apb(1'b1, SLVM_GIE_OFFS, 32'h1);
    apb(1'b1, SLVM_IRQC_OFFS, 32'h20);
    chk(supply_irq, 1'b0);
    idle_state <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(idle_wake, 1'b0);
    apb(1'b0, SLVM_IRQC_OFFS, '0);
    chk({rv, idle_wake}, {32'h20, 1'b0});
    comp_low <= 1'b0;
    idle_state <= 1'b0;
    $display("interrupt done");
    stop_test();
  end
endmodule // tb_top
